/* File: verilog/eip_cfg.svh */
// Register map, reset values, field positions and vector numbers of the prioritizer
`ifndef EIP_CFG_SVH
`define EIP_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define EIP_IDX_EDGE1      16'hfff2
`define EIP_IDX_EDGE2      16'hfff3
`define EIP_IDX_EN1        16'hfff4
`define EIP_IDX_EN2        16'hfff5
`define EIP_IDX_EN3        16'hfff6
`define EIP_IDX_FLAG1      16'hfff7
`define EIP_IDX_FLAG2      16'hfff8
`define EIP_IDX_FLAG3      16'hfff9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EIP_RST_EDGE1      8'h70
`define EIP_RST_EDGE2      8'h00
`define EIP_RST_EN1        8'h10
`define EIP_RST_EN2        8'h00
`define EIP_RST_EN3        8'h00
`define EIP_RST_FLAG1      8'h10
`define EIP_RST_FLAG2      8'h00
`define EIP_RST_FLAG3      8'h00

// ----------------------------------------
// Writable masks and fixed bits
// ----------------------------------------
`define EIP_EDGE1_WMASK    8'h0f
`define EIP_EDGE1_FIXED    8'h70
`define EIP_GRP1_WMASK     8'hcf
`define EIP_GRP1_FIXED     8'h10
`define EIP_GRP2_WMASK     8'hd0

// ----------------------------------------
// Field positions in first and second enable / flag registers
// ----------------------------------------
`define EIP_BIT_TB1        7
`define EIP_BIT_TA         6
`define EIP_BIT_DT         7
`define EIP_BIT_AD         6
`define EIP_BIT_S1         4

// ----------------------------------------
// Vector numbers
// ----------------------------------------
`define EIP_VEC_RESET      5'h00
`define EIP_VEC_PRIMARY0   5'h04
`define EIP_VEC_SECONDARY  5'h08
`define EIP_VEC_TIMER_A    5'h0a
`define EIP_VEC_TIMER_B1   5'h0b
`define EIP_VEC_TIMER_X    5'h10
`define EIP_VEC_TIMER_V    5'h11
`define EIP_VEC_SERIAL1    5'h13
`define EIP_VEC_SERIAL3    5'h15
`define EIP_VEC_CONVERTER  5'h16
`define EIP_VEC_DIRECT     5'h17

`endif

/* File: verilog/eip_pkg.sv */
// Types shared by the edge interrupt prioritizer
package eip_pkg;

	typedef logic [4:0]  eip_vec_t;
	typedef logic [15:0] eip_vaddr_t;

	typedef enum logic [0:0] {
		EIP_ST_HOLD = 1'b0,
		EIP_ST_RUN  = 1'b1
	} eip_state_t;

endpackage

/* File: verilog/eip_top.sv */
// Edge interrupt prioritizer: edge detect, flags, enables, priority, Wishbone registers
// Operation
// - Twelve external pins, twenty-one internal requests
// - Only highest fixed priority request is serviced
// - Global mask blocks acceptance, flags still set
// - Each external pin has own edge select
// - Fixed vector numbers, address twice the number
// - Seven timer X events share vector 16
// - Three timer V events share vector 17
// - Six serial channel 3 events share 21
// - Reserved vector locations are never issued
// - Eight registers at consecutive indices fff2-fff9
// - Flag writes clear on 0, keep on 1
// - First edge select bits 3-0 pick pin edge
// - First edge select bit7 zero, 6-4 one
// - First edge select resets to 70
// - Second edge select resets to 00
// - Second edge select bit 7 serves pin 7
// - Bit 6 also sets timer B1 event edge
// - Bit 5 also sets converter trigger edge
// - Bits 4-0 serve secondary pins 4-0
// - Flags stay set on accept until cleared
// - Enable bit gates its source
// - Accept only at instruction boundary
// - No interrupt before first instruction after reset
//
// The Wishbone slave port was left to the implementer.
`include "eip_cfg.svh"

// ----------------------------------------
// Pin synchroniser and selectable edge detector
// ----------------------------------------
module eip_edge (
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	input  wire logic i_pin,
	input  wire logic i_rising,
	output logic      o_edge
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			meta_reg <= i_pin;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Rising when selected, falling otherwise
	assign o_edge = i_rising ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg);
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module eip_top #(
	parameter int N_PRIMARY   = 4,
	parameter int N_SECONDARY = 8
) (
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_rstn,
	// Wishbone classic slave
	input  wire logic                      i_wb_cyc,
	input  wire logic                      i_wb_stb,
	input  wire logic                      i_wb_we,
	input  wire logic [17:0]               i_wb_adr,
	input  wire logic [3:0]                i_wb_sel,
	input  wire logic [31:0]               i_wb_dat,
	output logic      [31:0]               o_wb_dat,
	output logic                           o_wb_ack,
	// External pins
	input  wire logic [N_PRIMARY-1:0]      i_primary_request_pins,
	input  wire logic [N_SECONDARY-1:0]    i_secondary_interrupt_pins,
	input  wire logic                      i_timer_b1_event_input,
	input  wire logic                      i_converter_external_trigger,
	output logic                           o_timer_b1_event_edge,
	output logic                           o_converter_trigger_edge,
	// Internal peripheral events
	input  wire logic                      i_timer_a_ovf,
	input  wire logic                      i_timer_b1_ovf,
	input  wire logic                      i_serial1_done,
	input  wire logic                      i_converter_end,
	input  wire logic                      i_direct_transfer,
	input  wire logic [6:0]                i_timer_x_req,
	input  wire logic [2:0]                i_timer_v_req,
	input  wire logic [5:0]                i_serial3_req,
	// CPU core
	input  wire logic                      i_ccr_mask,
	input  wire logic                      i_instr_boundary,
	output logic                           o_irq_request,
	output logic                           o_irq_accept,
	output logic [4:0]                     o_vector_num,
	output logic [15:0]                    o_vector_addr
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] primary_pin_edge_select_reg;
	logic [7:0] secondary_pin_edge_select_reg;
	logic [7:0] interrupt_enable_first_reg;
	logic [7:0] interrupt_enable_second_reg;
	logic [7:0] interrupt_enable_third_reg;
	logic [7:0] request_flags_first_reg;
	logic [7:0] request_flags_second_reg;
	logic [7:0] request_flags_third_reg;
	logic [7:0] flags1_next;
	logic [7:0] flags2_next;
	logic [7:0] flags3_next;

	logic                   ack_reg;
	logic [31:0]            rdata_reg;
	logic [7:0]             rdata_next;
	logic                   wb_req;
	logic                   wr_en;
	logic [15:0]            idx;
	logic [7:0]             wd;

	logic [N_PRIMARY-1:0]   prim_edge;
	logic [N_SECONDARY-1:0] sec_edge;
	logic [N_PRIMARY-1:0]   prim_sel;

	eip_pkg::eip_state_t    state_reg;
	logic                   accept_reg;
	eip_pkg::eip_vec_t      vec_reg;
	eip_pkg::eip_vec_t      vec_next;
	logic                   any_req;

	assign wb_req = i_wb_cyc & i_wb_stb & ~ack_reg;
	// Write lands on the edge where the master sees ack
	assign wr_en  = i_wb_cyc & i_wb_stb & ack_reg & i_wb_we & i_wb_sel[0];
	assign idx    = i_wb_adr[17:2];
	assign wd     = i_wb_dat[7:0];

	// ----------------------------------------
	// Edge detectors
	// ----------------------------------------
	assign prim_sel = primary_pin_edge_select_reg[N_PRIMARY-1:0];

	genvar g;
	generate
		for (g = 0; g < N_PRIMARY; g++) begin : g_prim
			eip_edge u_edge (
				.i_ref_clk (i_ref_clk),
				.i_rstn    (i_rstn),
				.i_pin     (i_primary_request_pins[g]),
				.i_rising  (prim_sel[g]),
				.o_edge    (prim_edge[g])
			);
		end
		for (g = 0; g < N_SECONDARY; g++) begin : g_sec
			eip_edge u_edge (
				.i_ref_clk (i_ref_clk),
				.i_rstn    (i_rstn),
				.i_pin     (i_secondary_interrupt_pins[g]),
				.i_rising  (secondary_pin_edge_select_reg[g]),
				.o_edge    (sec_edge[g])
			);
		end
	endgenerate

	// Timer B1 event pin shares secondary pin 6 edge select
	eip_edge u_tmb_edge (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_pin     (i_timer_b1_event_input),
		.i_rising  (secondary_pin_edge_select_reg[6]),
		.o_edge    (o_timer_b1_event_edge)
	);

	// Converter trigger pin shares secondary pin 5 edge select
	eip_edge u_adt_edge (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_pin     (i_converter_external_trigger),
		.i_rising  (secondary_pin_edge_select_reg[5]),
		.o_edge    (o_converter_trigger_edge)
	);

	// ----------------------------------------
	// Edge select and enable registers
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			primary_pin_edge_select_reg   <= `EIP_RST_EDGE1;
			secondary_pin_edge_select_reg <= `EIP_RST_EDGE2;
			interrupt_enable_first_reg    <= `EIP_RST_EN1;
			interrupt_enable_second_reg   <= `EIP_RST_EN2;
			interrupt_enable_third_reg    <= `EIP_RST_EN3;
		end else if (wr_en) begin
			case (idx)
				`EIP_IDX_EDGE1: primary_pin_edge_select_reg <=
					(wd & `EIP_EDGE1_WMASK) | `EIP_EDGE1_FIXED;
				`EIP_IDX_EDGE2: secondary_pin_edge_select_reg <= wd;
				`EIP_IDX_EN1: interrupt_enable_first_reg <=
					(wd & `EIP_GRP1_WMASK) | `EIP_GRP1_FIXED;
				`EIP_IDX_EN2: interrupt_enable_second_reg <= wd & `EIP_GRP2_WMASK;
				`EIP_IDX_EN3: interrupt_enable_third_reg <= wd;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Request flags: events set, write 0 clears, set wins
	// ----------------------------------------
	always_comb begin
		flags1_next = request_flags_first_reg;
		flags2_next = request_flags_second_reg;
		flags3_next = request_flags_third_reg;
		if (wr_en && idx == `EIP_IDX_FLAG1) begin
			flags1_next = flags1_next & wd;
		end
		if (wr_en && idx == `EIP_IDX_FLAG2) begin
			flags2_next = flags2_next & wd;
		end
		if (wr_en && idx == `EIP_IDX_FLAG3) begin
			flags3_next = flags3_next & wd;
		end
		// Events set regardless of mask or acceptance
		flags1_next[N_PRIMARY-1:0] = flags1_next[N_PRIMARY-1:0] | prim_edge;
		flags1_next[`EIP_BIT_TA]   = flags1_next[`EIP_BIT_TA] | i_timer_a_ovf;
		flags1_next[`EIP_BIT_TB1]  = flags1_next[`EIP_BIT_TB1] | i_timer_b1_ovf;
		flags2_next[`EIP_BIT_S1]   = flags2_next[`EIP_BIT_S1] | i_serial1_done;
		flags2_next[`EIP_BIT_AD]   = flags2_next[`EIP_BIT_AD] | i_converter_end;
		flags2_next[`EIP_BIT_DT]   = flags2_next[`EIP_BIT_DT] | i_direct_transfer;
		flags3_next = flags3_next | sec_edge;
		flags1_next = (flags1_next & `EIP_GRP1_WMASK) | `EIP_GRP1_FIXED;
		flags2_next = flags2_next & `EIP_GRP2_WMASK;
	end

	// Acceptance never clears a flag
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			request_flags_first_reg  <= `EIP_RST_FLAG1;
			request_flags_second_reg <= `EIP_RST_FLAG2;
			request_flags_third_reg  <= `EIP_RST_FLAG3;
		end else begin
			request_flags_first_reg  <= flags1_next;
			request_flags_second_reg <= flags2_next;
			request_flags_third_reg  <= flags3_next;
		end
	end

	// ----------------------------------------
	// Gating and fixed priority
	// ----------------------------------------
	logic [7:0] act1;
	logic [7:0] act2;
	logic [7:0] act3;
	logic       act_sec;
	logic       act_tx;
	logic       act_tv;
	logic       act_s3;

	assign act1    = request_flags_first_reg & interrupt_enable_first_reg;
	assign act2    = request_flags_second_reg & interrupt_enable_second_reg;
	assign act3    = request_flags_third_reg & interrupt_enable_third_reg;
	assign act_sec = |act3;
	assign act_tx  = |i_timer_x_req;
	assign act_tv  = |i_timer_v_req;
	assign act_s3  = |i_serial3_req;

	always_comb begin
		vec_next = `EIP_VEC_RESET;
		any_req  = 1'b1;
		if (act1[0]) begin
			vec_next = `EIP_VEC_PRIMARY0;
		end else if (act1[1]) begin
			vec_next = `EIP_VEC_PRIMARY0 + 5'h01;
		end else if (act1[2]) begin
			vec_next = `EIP_VEC_PRIMARY0 + 5'h02;
		end else if (act1[3]) begin
			vec_next = `EIP_VEC_PRIMARY0 + 5'h03;
		end else if (act_sec) begin
			vec_next = `EIP_VEC_SECONDARY;
		end else if (act1[`EIP_BIT_TA]) begin
			vec_next = `EIP_VEC_TIMER_A;
		end else if (act1[`EIP_BIT_TB1]) begin
			vec_next = `EIP_VEC_TIMER_B1;
		end else if (act_tx) begin
			vec_next = `EIP_VEC_TIMER_X;
		end else if (act_tv) begin
			vec_next = `EIP_VEC_TIMER_V;
		end else if (act2[`EIP_BIT_S1]) begin
			vec_next = `EIP_VEC_SERIAL1;
		end else if (act_s3) begin
			vec_next = `EIP_VEC_SERIAL3;
		end else if (act2[`EIP_BIT_AD]) begin
			vec_next = `EIP_VEC_CONVERTER;
		end else if (act2[`EIP_BIT_DT]) begin
			vec_next = `EIP_VEC_DIRECT;
		end else begin
			any_req = 1'b0;
		end
	end

	// Request to CPU only while mask clear and past first instruction
	assign o_irq_request = any_req & ~i_ccr_mask & (state_reg == eip_pkg::EIP_ST_RUN);

	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= eip_pkg::EIP_ST_HOLD;
		end else begin
			case (state_reg)
				eip_pkg::EIP_ST_HOLD: begin
					if (i_instr_boundary) begin
						state_reg <= eip_pkg::EIP_ST_RUN;
					end
				end
				eip_pkg::EIP_ST_RUN: state_reg <= eip_pkg::EIP_ST_RUN;
				default: state_reg <= eip_pkg::EIP_ST_HOLD;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			accept_reg <= 1'b0;
			vec_reg    <= `EIP_VEC_RESET;
		end else begin
			accept_reg <= o_irq_request & i_instr_boundary;
			if (o_irq_request && i_instr_boundary) begin
				vec_reg <= vec_next;
			end
		end
	end

	assign o_irq_accept  = accept_reg;
	assign o_vector_num  = vec_reg;
	assign o_vector_addr = {10'h000, vec_reg, 1'b0};

	// ----------------------------------------
	// Wishbone read data and acknowledge
	// ----------------------------------------
	always_comb begin
		case (idx)
			`EIP_IDX_EDGE1: rdata_next = primary_pin_edge_select_reg;
			`EIP_IDX_EDGE2: rdata_next = secondary_pin_edge_select_reg;
			`EIP_IDX_EN1:   rdata_next = interrupt_enable_first_reg;
			`EIP_IDX_EN2:   rdata_next = interrupt_enable_second_reg;
			`EIP_IDX_EN3:   rdata_next = interrupt_enable_third_reg;
			`EIP_IDX_FLAG1: rdata_next = request_flags_first_reg;
			`EIP_IDX_FLAG2: rdata_next = request_flags_second_reg;
			`EIP_IDX_FLAG3: rdata_next = request_flags_third_reg;
			default:        rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_req;
			if (wb_req) begin
				rdata_reg <= {24'h000000, rdata_next};
			end
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdata_reg;
endmodule

/* File: tb/eip_properties.sv */
// Checker of bus answers, acceptance and vectors of the prioritizer
module eip_properties (
	input wire logic        i_ref_clk,
	input wire logic        i_rstn,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        i_ccr_mask,
	input wire logic        i_instr_boundary,
	input wire logic        o_irq_request,
	input wire logic        o_irq_accept,
	input wire logic [4:0]  o_vector_num,
	input wire logic [15:0] o_vector_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	logic take;
	assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_ack_follows: assert property (take |=> o_wb_ack)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (o_wb_ack |-> $past(take))
		else $error("ack without request");
	a_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_mask_blocks: assert property (i_ccr_mask |-> !o_irq_request)
		else $error("request while masked");
	a_accept_taken: assert property (o_irq_request && i_instr_boundary |=> o_irq_accept)
		else $error("boundary with request not accepted");
	a_accept_cause: assert property (o_irq_accept |-> $past(o_irq_request && i_instr_boundary))
		else $error("accept outside a boundary");
	a_vec_addr: assert property (o_vector_addr == {10'h000, o_vector_num, 1'b0})
		else $error("vector address not twice the number");
	a_vec_legal: assert property (o_irq_accept |->
		o_vector_num inside {[5'h04:5'h08], 5'h0a, 5'h0b, 5'h10, 5'h11, 5'h13, [5'h15:5'h17]})
		else $error("reserved vector issued");
	a_vec_hold: assert property (!o_irq_accept |-> $stable(o_vector_num))
		else $error("vector changed without accept");
	c_accept: cover property (o_irq_accept);
	c_masked_boundary: cover property (i_ccr_mask && i_instr_boundary);
	c_bus: cover property (take ##1 o_wb_ack);
endmodule

bind eip_top eip_properties i_props (
	.i_ref_clk       (i_ref_clk),
	.i_rstn          (i_rstn),
	.i_wb_cyc        (i_wb_cyc),
	.i_wb_stb        (i_wb_stb),
	.o_wb_dat        (o_wb_dat),
	.o_wb_ack        (o_wb_ack),
	.i_ccr_mask      (i_ccr_mask),
	.i_instr_boundary(i_instr_boundary),
	.o_irq_request   (o_irq_request),
	.o_irq_accept    (o_irq_accept),
	.o_vector_num    (o_vector_num),
	.o_vector_addr   (o_vector_addr)
);

/* File: tb/eip_cpu_model.sv */
// CPU core model: mask bit and instruction boundary pulses
module eip_cpu_model (
	input  wire logic i_ref_clk,
	output logic      o_mask,
	output logic      o_boundary
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_mask = 1'b1; // Mask set out of reset
		o_boundary = 1'b0;
	end
	task automatic set_mask(input logic m);
		@(posedge i_ref_clk) o_mask <= m;
	endtask
	// Boundary after a random stretch of execution
	task automatic step();
		int d;
		d = $urandom_range(3, 0);
		repeat (d) @(posedge i_ref_clk);
		@(posedge i_ref_clk) o_boundary <= 1'b1;
		@(posedge i_ref_clk) o_boundary <= 1'b0;
	endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the edge interrupt prioritizer
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [17:0] adr = '0;
	logic [31:0] wdat = '0;
	logic [3:0]  sel = 4'h0;
	logic [3:0]  pri = 4'hf;
	logic [7:0]  sec = 8'hff;
	logic        timer_b1_event_input = 1'b1;
	logic        trig = 1'b1;
	logic [4:0]  ev = '0;
	logic [6:0]  tx = '0;
	logic [2:0]  tv = '0;
	logic [5:0]  s3 = '0;
	logic [31:0] rdat;
	logic        ack, req, acc, mask, bnd, tbe, cte;
	logic [4:0]  vnum, v_exp;
	logic [15:0] vaddr;
	logic [7:0]  r;
	logic [7:0]  rq[$];
	logic [4:0]  aq[$];
	int          n_errors = 0, total_checks = 0, n_tbe = 0, n_cte = 0;
	logic [7:0]  rst_tab[8] = '{8'h70, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
	logic [4:0]  vtab[3] = '{5'h13, 5'h16, 5'h17};
	logic [7:0]  ctab[3] = '{8'hef, 8'hbf, 8'h00};
	logic [4:0]  ltab[3] = '{5'h10, 5'h11, 5'h15};

	always #50 clk = ~clk;

	eip_cpu_model i_cpu (.i_ref_clk(clk), .o_mask(mask), .o_boundary(bnd));

	eip_top i_dut (
		.i_ref_clk                   (clk),
		.i_rstn                      (rstn),
		.i_wb_cyc                    (cyc),
		.i_wb_stb                    (stb),
		.i_wb_we                     (we),
		.i_wb_adr                    (adr),
		.i_wb_sel                    (sel),
		.i_wb_dat                    (wdat),
		.o_wb_dat                    (rdat),
		.o_wb_ack                    (ack),
		.i_primary_request_pins      (pri),
		.i_secondary_interrupt_pins  (sec),
		.i_timer_b1_event_input      (timer_b1_event_input),
		.i_converter_external_trigger(trig),
		.o_timer_b1_event_edge       (tbe),
		.o_converter_trigger_edge    (cte),
		.i_timer_a_ovf               (ev[0]),
		.i_timer_b1_ovf              (ev[1]),
		.i_serial1_done              (ev[2]),
		.i_converter_end             (ev[3]),
		.i_direct_transfer           (ev[4]),
		.i_timer_x_req               (tx),
		.i_timer_v_req               (tv),
		.i_serial3_req               (s3),
		.i_ccr_mask                  (mask),
		.i_instr_boundary            (bnd),
		.o_irq_request               (req),
		.o_irq_accept                (acc),
		.o_vector_num                (vnum),
		.o_vector_addr               (vaddr)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) chk(32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
	endtask

	task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
		rq.push_back(exp);
		wb(1'b0, idx, 8'h00);
	endtask

	task automatic expect_acc(input logic [4:0] v);
		aq.push_back(v);
		i_cpu.step();
		repeat (3) @(posedge clk);
	endtask

	task automatic pulse(input logic [4:0] p);
		@(posedge clk) ev <= p;
		@(posedge clk) ev <= '0;
		repeat (2) @(posedge clk);
	endtask

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	always @(posedge clk) begin
		if (ack === 1'b1 && !we) begin
			if (rq.size() == 0) chk(32'h1, 32'h0);
			else chk(rdat, {24'h000000, rq.pop_front()});
		end
		if (acc === 1'b1) begin
			if (aq.size() == 0) chk(32'h1, 32'h0);
			else begin
				v_exp = aq.pop_front();
				chk(32'(vnum), 32'(v_exp));
				chk(32'(vaddr), 32'({v_exp, 1'b0}));
			end
		end
		if (tbe === 1'b1) n_tbe++;
		if (cte === 1'b1) n_cte++;
	end

	initial begin
		#(20000 * 100);
		n_errors++;
		report_and_stop();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'h8ea4));
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(16'(16'hfff2 + i), rst_tab[i]);
		rd(16'hfffa, 8'h00);
		$display("test 1 done");
		r = 8'($urandom);
		wb(1'b1, 16'hfff2, r);
		rd(16'hfff2, {4'h7, r[3:0]});
		wb(1'b1, 16'hfff3, ~r);
		rd(16'hfff3, ~r);
		wb(1'b1, 16'hfff2, 8'h00);
		wb(1'b1, 16'hfff4, 8'h0f);
		$display("test 2 done");
		@(posedge clk) pri <= 4'b1010;
		repeat (6) @(posedge clk);
		rd(16'hfff7, 8'h15);
		i_cpu.step();
		chk(32'(req), 32'h0);
		i_cpu.set_mask(1'b0);
		expect_acc(5'h04);
		expect_acc(5'h04);
		wb(1'b1, 16'hfff7, 8'hfe);
		rd(16'hfff7, 8'h14);
		expect_acc(5'h06);
		@(posedge clk) pri <= 4'hf;
		wb(1'b1, 16'hfff7, 8'h00);
		rd(16'hfff7, 8'h10);
		$display("test 3 done");
		wb(1'b1, 16'hfff3, 8'h60);
		wb(1'b1, 16'hfff6, 8'h40);
		@(posedge clk) sec <= 8'h1f;
		timer_b1_event_input <= 1'b0;
		trig <= 1'b0;
		repeat (6) @(posedge clk);
		rd(16'hfff9, 8'h80);
		@(posedge clk) sec <= 8'hff;
		timer_b1_event_input <= 1'b1;
		trig <= 1'b1;
		repeat (6) @(posedge clk);
		rd(16'hfff9, 8'he0);
		chk(n_tbe, 1);
		chk(n_cte, 1);
		expect_acc(5'h08);
		wb(1'b1, 16'hfff9, 8'h00);
		$display("test 4 done");
		wb(1'b1, 16'hfff4, 8'h00);
		pulse(5'b00001);
		i_cpu.step();
		chk(32'(req), 32'h0);
		wb(1'b1, 16'hfff4, 8'hc0);
		pulse(5'b00010);
		expect_acc(5'h0a);
		wb(1'b1, 16'hfff7, 8'hbf);
		expect_acc(5'h0b);
		wb(1'b1, 16'hfff7, 8'h00);
		wb(1'b1, 16'hfff5, 8'hd0);
		pulse(5'b11100);
		for (int k = 0; k < 3; k++) begin
			expect_acc(vtab[k]);
			wb(1'b1, 16'hfff8, ctab[k]);
		end
		$display("test 5 done");
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) tx <= (k == 0) ? 7'(1 << $urandom_range(6, 0)) : 7'h00;
			tv <= (k == 1) ? 3'(1 << $urandom_range(2, 0)) : 3'h0;
			s3 <= (k == 2) ? 6'(1 << $urandom_range(5, 0)) : 6'h00;
			expect_acc(ltab[k]);
			@(posedge clk) tx <= '0;
			tv <= '0;
			s3 <= '0;
			repeat (2) @(posedge clk);
		end
		$display("test 6 done");
		report_and_stop();
	end
endmodule
